// ### gpio_port78_map.vh
// Register map and constants for the port 7 / port 8 GPIO block with LCD pin sharing
`ifndef GPIO_PORT78_MAP_VH
`define GPIO_PORT78_MAP_VH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define PORT7_DATA_IDX 16'hffda
`define PORT8_DATA_IDX 16'hffdb
`define PORT7_DIRECTION_IDX 16'hffea
`define PORT8_DIRECTION_IDX 16'hffeb
`define LCD_PORT_CONTROL_IDX 16'hffc0
`define REG_ADDR_W 18
`define PORT7_DATA_ADDR 18'h3ff68
`define PORT8_DATA_ADDR 18'h3ff6c
`define PORT7_DIRECTION_ADDR 18'h3ffa8
`define PORT8_DIRECTION_ADDR 18'h3ffac
`define LCD_PORT_CONTROL_ADDR 18'h3ff00

// ----------------------------------------
// Reset values and read constants
// ----------------------------------------
`define PORT_DATA_RST 8'h00
`define PORT_DIRECTION_RST 8'h00
`define LCD_PORT_CONTROL_RST 5'h00
`define WRITE_ONLY_READ 8'hff

// ----------------------------------------
// Field positions in lcd_port_control
// ----------------------------------------
`define SEG_SEL_MSB 3
`define SEG_SEL_LSB 0
`define LCD_EXT_BIT 4
`define LCD_CTRL_W 5

// ----------------------------------------
// AXI responses
// ----------------------------------------
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ### pin_mux.v
// Per-port pin function selection between GPIO and LCD drive
`timescale 1ns/100ps
`default_nettype none

module pin_mux #(
	parameter WIDTH = 8
) (
	input wire [WIDTH-1:0] data,
	input wire [WIDTH-1:0] direction,
	input wire [WIDTH-1:0] gpio_en,
	input wire [WIDTH-1:0] seg_en,
	input wire [WIDTH-1:0] seg_val,
	input wire [WIDTH-1:0] alt_en,
	input wire [WIDTH-1:0] alt_val,
	output reg [WIDTH-1:0] out_nxt,
	output reg [WIDTH-1:0] oe_nxt
);

	integer i;

	// Alternate LCD function beats segment, segment beats GPIO
	always @* begin
		out_nxt = {WIDTH{1'b0}};
		oe_nxt = {WIDTH{1'b0}};
		for (i = 0; i < WIDTH; i = i + 1) begin
			if (alt_en[i]) begin
				out_nxt[i] = alt_val[i];
				oe_nxt[i] = 1'b1;
			end else if (seg_en[i]) begin
				out_nxt[i] = seg_val[i];
				oe_nxt[i] = 1'b1;
			end else if (gpio_en[i] && direction[i]) begin
				out_nxt[i] = data[i];
				oe_nxt[i] = 1'b1;
			end
		end
	end

endmodule // pin_mux

`default_nettype wire

// ### gpio_port78.v
// Port 7 and port 8 GPIO with LCD segment sharing behind an AXI4-Lite slave
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port78_map.vh"

module gpio_port78 #(
	parameter WIDTH = 8
) (
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address
	input wire [`REG_ADDR_W-1:0] s_axi_awaddr,
	input wire [2:0] s_axi_awprot,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [`REG_ADDR_W-1:0] s_axi_araddr,
	input wire [2:0] s_axi_arprot,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// Power state from the system controller
	input wire standby_mode,
	input wire sleep_mode,
	// LCD controller drive
	input wire [WIDTH-1:0] lcd_segment_out_p7,
	input wire [WIDTH-1:0] lcd_segment_out_p8,
	input wire lcd_clock_one_out,
	// Port 7 pins
	input wire [WIDTH-1:0] port7_pin_in,
	output reg [WIDTH-1:0] port7_pin_out,
	output reg [WIDTH-1:0] port7_pin_oe,
	// Port 8 pins
	input wire [WIDTH-1:0] port8_pin_in,
	output reg [WIDTH-1:0] port8_pin_out,
	output reg [WIDTH-1:0] port8_pin_oe
);

	// ----------------------------------------
	// Address decode helpers
	// ----------------------------------------
	localparam [2:0] SEL_NONE = 3'd0;
	localparam [2:0] SEL_P7_DATA = 3'd1;
	localparam [2:0] SEL_P8_DATA = 3'd2;
	localparam [2:0] SEL_P7_DIR = 3'd3;
	localparam [2:0] SEL_P8_DIR = 3'd4;
	localparam [2:0] SEL_LCD_CTRL = 3'd5;

	function [2:0] decode;
		input [`REG_ADDR_W-1:0] addr;
		begin
			if (addr == `PORT7_DATA_ADDR) begin
				decode = SEL_P7_DATA;
			end else if (addr == `PORT8_DATA_ADDR) begin
				decode = SEL_P8_DATA;
			end else if (addr == `PORT7_DIRECTION_ADDR) begin
				decode = SEL_P7_DIR;
			end else if (addr == `PORT8_DIRECTION_ADDR) begin
				decode = SEL_P8_DIR;
			end else if (addr == `LCD_PORT_CONTROL_ADDR) begin
				decode = SEL_LCD_CTRL;
			end else begin
				decode = SEL_NONE;
			end
		end
	endfunction

	// ----------------------------------------
	// Register state
	// ----------------------------------------
	reg [WIDTH-1:0] port7_data_r;
	reg [WIDTH-1:0] port8_data_r;
	reg [WIDTH-1:0] port7_direction_r;
	reg [WIDTH-1:0] port8_direction_r;
	reg [`LCD_CTRL_W-1:0] lcd_port_control_r;

	// Write channel holding state
	reg aw_held_r;
	reg [`REG_ADDR_W-1:0] aw_addr_r;
	reg w_held_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;

	wire aw_take;
	wire w_take;
	wire wr_fire;
	wire [2:0] wr_sel;
	wire wr_lane0;
	wire [2:0] rd_sel;
	wire ar_take;

	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
	assign wr_sel = decode(aw_addr_r);
	assign wr_lane0 = w_strb_r[0];
	assign rd_sel = decode(s_axi_araddr);
	assign ar_take = s_axi_arvalid && s_axi_arready;

	// ----------------------------------------
	// Write address and data capture
	// ----------------------------------------
	// Either channel may arrive first; each is held until the write is done
	always @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			aw_addr_r <= {`REG_ADDR_W{1'b0}};
			w_held_r <= 1'b0;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			if (aw_take) begin
				aw_held_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
			end else if (wr_fire) begin
				aw_held_r <= 1'b0;
			end
			if (w_take) begin
				w_held_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end else if (wr_fire) begin
				w_held_r <= 1'b0;
			end
			s_axi_awready <= !aw_held_r && !aw_take && !s_axi_bvalid;
			s_axi_wready <= !w_held_r && !w_take && !s_axi_bvalid;
		end
	end

	// ----------------------------------------
	// Write response
	// ----------------------------------------
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= (wr_sel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	// Only byte lane 0 carries register bits; other lanes are ignored
	always @(posedge aclk) begin
		if (!aresetn) begin
			port7_data_r <= `PORT_DATA_RST;
			port8_data_r <= `PORT_DATA_RST;
			port7_direction_r <= `PORT_DIRECTION_RST;
			port8_direction_r <= `PORT_DIRECTION_RST;
			lcd_port_control_r <= `LCD_PORT_CONTROL_RST;
		end else if (wr_fire && wr_lane0) begin
			if (wr_sel == SEL_P7_DATA) begin
				port7_data_r <= w_data_r[WIDTH-1:0];
			end else if (wr_sel == SEL_P8_DATA) begin
				port8_data_r <= w_data_r[WIDTH-1:0];
			end else if (wr_sel == SEL_P7_DIR) begin
				port7_direction_r <= w_data_r[WIDTH-1:0];
			end else if (wr_sel == SEL_P8_DIR) begin
				port8_direction_r <= w_data_r[WIDTH-1:0];
			end else if (wr_sel == SEL_LCD_CTRL) begin
				lcd_port_control_r <= w_data_r[`LCD_CTRL_W-1:0];
			end
		end
	end

	// ----------------------------------------
	// Read path
	// ----------------------------------------
	reg [31:0] rd_data_nxt;
	reg [1:0] rd_resp_nxt;
	wire [WIDTH-1:0] port7_read;
	wire [WIDTH-1:0] port8_read;

	// Output bits return the latch, input bits the pin
	assign port7_read = (port7_direction_r & port7_data_r) | (~port7_direction_r & port7_pin_in);
	assign port8_read = (port8_direction_r & port8_data_r) | (~port8_direction_r & port8_pin_in);

	always @* begin
		rd_data_nxt = 32'h0000_0000;
		rd_resp_nxt = `RESP_OKAY;
		case (rd_sel)
			SEL_P7_DATA: begin
				rd_data_nxt[WIDTH-1:0] = port7_read;
			end
			SEL_P8_DATA: begin
				rd_data_nxt[WIDTH-1:0] = port8_read;
			end
			SEL_P7_DIR: begin
				rd_data_nxt[WIDTH-1:0] = `WRITE_ONLY_READ;
			end
			SEL_P8_DIR: begin
				rd_data_nxt[WIDTH-1:0] = `WRITE_ONLY_READ;
			end
			SEL_LCD_CTRL: begin
				rd_data_nxt[`LCD_CTRL_W-1:0] = lcd_port_control_r;
			end
			default: begin
				rd_resp_nxt = `RESP_SLVERR;
			end
		endcase
	end

	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !ar_take;
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_data_nxt;
				s_axi_rresp <= rd_resp_nxt;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// Pin function selection
	// ----------------------------------------
	wire [3:0] seg_sel;
	wire lcd_ext;
	wire p7_gpio;
	wire p8_gpio;
	wire [WIDTH-1:0] p8_alt_en;
	wire [WIDTH-1:0] p8_alt_val;
	wire [WIDTH-1:0] p7_out_nxt;
	wire [WIDTH-1:0] p7_oe_nxt;
	wire [WIDTH-1:0] p8_out_nxt;
	wire [WIDTH-1:0] p8_oe_nxt;

	assign seg_sel = lcd_port_control_r[`SEG_SEL_MSB:`SEG_SEL_LSB];
	assign lcd_ext = lcd_port_control_r[`LCD_EXT_BIT];
	// Port 7 belongs to GPIO for select 00**, to segments for 01** and 1***
	assign p7_gpio = (seg_sel[3:2] == 2'b00);
	// Port 8 belongs to GPIO for select 000*, to segments for 001*, 01**, 1***
	assign p8_gpio = (seg_sel[3:1] == 3'b000);
	// Extended mode hands pin 7 to LCD clock one
	assign p8_alt_en = {lcd_ext, {(WIDTH-1){1'b0}}};
	assign p8_alt_val = {lcd_clock_one_out, {(WIDTH-1){1'b0}}};

	pin_mux #(
		.WIDTH(WIDTH)
	) u_port7_mux (
		.data(port7_data_r),
		.direction(port7_direction_r),
		.gpio_en({WIDTH{p7_gpio}}),
		.seg_en({WIDTH{!p7_gpio}}),
		.seg_val(lcd_segment_out_p7),
		.alt_en({WIDTH{1'b0}}),
		.alt_val({WIDTH{1'b0}}),
		.out_nxt(p7_out_nxt),
		.oe_nxt(p7_oe_nxt)
	);

	pin_mux #(
		.WIDTH(WIDTH)
	) u_port8_mux (
		.data(port8_data_r),
		.direction(port8_direction_r),
		.gpio_en({WIDTH{p8_gpio}} & ~p8_alt_en),
		.seg_en({WIDTH{!p8_gpio}} & ~p8_alt_en),
		.seg_val(lcd_segment_out_p8),
		.alt_en(p8_alt_en),
		.alt_val(p8_alt_val),
		.out_nxt(p8_out_nxt),
		.oe_nxt(p8_oe_nxt)
	);

	// ----------------------------------------
	// Pin drivers and power states
	// ----------------------------------------
	// Standby floats pins, sleep freezes them, otherwise follow the mux
	always @(posedge aclk) begin
		if (!aresetn) begin
			port7_pin_out <= {WIDTH{1'b0}};
			port7_pin_oe <= {WIDTH{1'b0}};
			port8_pin_out <= {WIDTH{1'b0}};
			port8_pin_oe <= {WIDTH{1'b0}};
		end else if (standby_mode) begin
			port7_pin_oe <= {WIDTH{1'b0}};
			port8_pin_oe <= {WIDTH{1'b0}};
		end else if (!sleep_mode) begin
			port7_pin_out <= p7_out_nxt;
			port7_pin_oe <= p7_oe_nxt;
			port8_pin_out <= p8_out_nxt;
			port8_pin_oe <= p8_oe_nxt;
		end
	end

endmodule // gpio_port78

`default_nettype wire

// ### pin_partner.sv
// Outside world on one 8-pin port: drives lines the block leaves released
`timescale 1ns/100ps
`default_nettype none
module pin_partner (
	input wire logic aclk,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_oe,
	input wire logic [7:0] drive,
	output logic [7:0] pin_in
);
	logic [7:0] tog = 8'h00;
	// Released lines wander each cycle so a stale value never passes
	always @(posedge aclk) begin
		tog <= ~tog;
	end
	assign pin_in = (pin_oe & pin_out) | (~pin_oe & (drive ^ tog));
endmodule // pin_partner
`default_nettype wire

// ### gpio_port78_sva.sv
// Port-level checks for the port 7 / port 8 block
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port78_map.vh"
module gpio_port78_sva #(
	parameter WIDTH = 8
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [`REG_ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic [`REG_ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic standby_mode,
	input wire logic sleep_mode,
	input wire logic [WIDTH-1:0] lcd_segment_out_p7,
	input wire logic [WIDTH-1:0] lcd_segment_out_p8,
	input wire logic lcd_clock_one_out,
	input wire logic [WIDTH-1:0] port7_pin_out,
	input wire logic [WIDTH-1:0] port7_pin_oe,
	input wire logic [WIDTH-1:0] port8_pin_out,
	input wire logic [WIDTH-1:0] port8_pin_oe
);
	logic [`REG_ADDR_W-1:0] aw_l;
	logic [4:0] wd_l;
	logic [4:0] ctl_r;
	logic [4:0] ctl;
	logic bv_q;
	logic run;
	// Control value the pin logic uses, counting a write landing now
	assign ctl = (s_axi_bvalid && !bv_q && aw_l == `LCD_PORT_CONTROL_ADDR) ? wd_l : ctl_r;
	assign run = aresetn && !standby_mode && !sleep_mode;
	always_ff @(posedge aclk) begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_l <= s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			wd_l <= s_axi_wdata[4:0];
		end
		bv_q <= aresetn && s_axi_bvalid;
		ctl_r <= aresetn ? ctl : 5'h00;
	end
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence rd_take(logic [`REG_ADDR_W-1:0] a);
		s_axi_arvalid && s_axi_arready && s_axi_araddr == a;
	endsequence
	a_p7_dir_ones: assert property (rd_take(`PORT7_DIRECTION_ADDR) |=> s_axi_rvalid && s_axi_rdata == 32'h000000ff)
		else $error("port7 direction read not all ones");
	a_p8_dir_ones: assert property (rd_take(`PORT8_DIRECTION_ADDR) |=> s_axi_rvalid && s_axi_rdata == 32'h000000ff)
		else $error("port8 direction read not all ones");
	a_reset_float: assert property (disable iff (1'b0) !aresetn |=> port7_pin_oe == 8'h00 && port8_pin_oe == 8'h00)
		else $error("pin driven in reset");
	a_standby_float: assert property (standby_mode |=> port7_pin_oe == 8'h00 && port8_pin_oe == 8'h00)
		else $error("pin driven in standby");
	a_sleep_hold: assert property (sleep_mode && !standby_mode |=> $stable(port7_pin_out) && $stable(port7_pin_oe)
		&& $stable(port8_pin_out) && $stable(port8_pin_oe)) else $error("pin changed in sleep");
	a_p7_segment: assert property (run && ctl[3:2] != 2'b00 |=> port7_pin_oe == 8'hff
		&& port7_pin_out == $past(lcd_segment_out_p7)) else $error("port7 segment drive wrong");
	a_p8_segment: assert property (run && !ctl[4] && ctl[3:1] != 3'b000 |=> port8_pin_oe == 8'hff
		&& port8_pin_out == $past(lcd_segment_out_p8)) else $error("port8 segment drive wrong");
	a_p8_clock: assert property (run && ctl[4] |=> port8_pin_oe[7] && port8_pin_out[7] == $past(lcd_clock_one_out))
		else $error("port8 pin7 clock drive wrong");
endmodule // gpio_port78_sva
`default_nettype wire

// ### tb_top.sv
// Self-checking bench for the port 7 / port 8 block
`timescale 1ns/100ps
`default_nettype none
`include "gpio_port78_map.vh"
module tb_top;
	logic aclk, aresetn, standby_mode, sleep_mode, lcd_clock_one_out, p7s, p8s;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [`REG_ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd, seed;
	logic [7:0] lcd_segment_out_p7, lcd_segment_out_p8, port7_pin_in, port7_pin_out, port7_pin_oe;
	logic [7:0] port8_pin_in, port8_pin_out, port8_pin_oe, w7, w8, s7, s8, d7, c7, d8, c8, eo, ex, hold;
	logic [4:0] sels [6] = '{5'h04, 5'h08, 5'h02, 5'h10, 5'h12, 5'h00};
	int n_errors, compares;
	gpio_port78 dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.standby_mode, .sleep_mode, .lcd_segment_out_p7, .lcd_segment_out_p8, .lcd_clock_one_out,
		.port7_pin_in, .port7_pin_out, .port7_pin_oe, .port8_pin_in, .port8_pin_out, .port8_pin_oe);
	pin_partner p7_u (.aclk, .pin_out(port7_pin_out), .pin_oe(port7_pin_oe), .drive(w7), .pin_in(port7_pin_in));
	pin_partner p8_u (.aclk, .pin_out(port8_pin_out), .pin_oe(port8_pin_oe), .drive(w8), .pin_in(port8_pin_in));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [7:0] rd_exp(logic [7:0] d, logic [7:0] c, logic [7:0] p);
		return (d & c) | (p & ~c);
	endfunction
	task automatic chk(string n, logic [31:0] e, logic [31:0] s);
		compares++;
		if (s !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(logic [`REG_ADDR_W-1:0] a, logic [31:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
	endtask
	task automatic rdt(logic [`REG_ADDR_W-1:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arvalid <= 1'b0;
				s7 = port7_pin_in;
				s8 = port8_pin_in;
			end
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rr = s_axi_rresp;
	endtask
	task automatic stop_test();
		if (n_errors == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	initial begin
		aclk = 1'b0;
		forever #2.5 aclk = ~aclk;
	end
	initial begin
		#100000;
		n_errors++;
		stop_test();
	end
	initial begin
		seed = 32'h46f7;
		n_errors = 0;
		compares = 0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, standby_mode, sleep_mode, lcd_clock_one_out, aresetn} = 7'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_awprot, s_axi_arprot} = '0;
		{lcd_segment_out_p7, lcd_segment_out_p8, w7, w8} = '0;
		{s_axi_bready, s_axi_rready, s_axi_wstrb} = 6'h3f;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		chk("oe after reset", 32'h0, 32'({port7_pin_oe, port8_pin_oe}));
		rdt(`PORT7_DATA_ADDR);
		chk("p7 read at reset", 32'(s7), rd);
		rdt(`PORT7_DIRECTION_ADDR);
		chk("p7 dir read", 32'h000000ff, rd);
		wr(`PORT8_DIRECTION_ADDR, 32'h000000ff);
		rdt(`PORT8_DATA_ADDR);
		chk("p8 data reset", 32'h0, rd);
		repeat (4) begin
			d7 = 8'(rnd());
			c7 = 8'(rnd());
			d8 = 8'(rnd());
			c8 = 8'(rnd());
			w7 <= 8'(rnd());
			w8 <= 8'(rnd());
			wr(`PORT7_DATA_ADDR, 32'(d7));
			wr(`PORT7_DIRECTION_ADDR, 32'(c7));
			wr(`PORT8_DATA_ADDR, 32'(d8));
			wr(`PORT8_DIRECTION_ADDR, 32'(c8));
			rdt(`PORT8_DIRECTION_ADDR);
			chk("p8 dir read", 32'h000000ff, rd);
			rdt(`PORT8_DATA_ADDR);
			chk("p8 read", 32'(rd_exp(d8, c8, s8)), rd);
		end
		foreach (sels[i]) begin
			lcd_segment_out_p7 <= 8'(rnd());
			lcd_segment_out_p8 <= 8'(rnd());
			lcd_clock_one_out <= 1'(rnd());
			wr(`LCD_PORT_CONTROL_ADDR, 32'(sels[i]));
			repeat (2) @(posedge aclk);
			p7s = sels[i][3:2] != 2'b00;
			p8s = sels[i][3:1] != 3'b000;
			eo = p7s ? 8'hff : c7;
			ex = p7s ? lcd_segment_out_p7 : d7;
			chk("p7 oe", 32'(eo), 32'(port7_pin_oe));
			chk("p7 out", 32'(ex & eo), 32'(port7_pin_out & eo));
			eo = p8s ? 8'hff : c8;
			ex = p8s ? lcd_segment_out_p8 : d8;
			eo[7] = eo[7] | sels[i][4];
			if (sels[i][4]) ex[7] = lcd_clock_one_out;
			chk("p8 oe", 32'(eo), 32'(port8_pin_oe));
			chk("p8 out", 32'(ex & eo), 32'(port8_pin_out & eo));
			rdt(`PORT7_DATA_ADDR);
			chk("p7 read", 32'(rd_exp(d7, c7, s7)), rd);
		end
		standby_mode <= 1'b1;
		repeat (2) @(posedge aclk);
		chk("standby oe", 32'h0, 32'({port7_pin_oe, port8_pin_oe}));
		standby_mode <= 1'b0;
		sleep_mode <= 1'b1;
		@(posedge aclk);
		hold = port7_pin_out;
		wr(`PORT7_DATA_ADDR, 32'(~d7));
		repeat (2) @(posedge aclk);
		chk("sleep out", 32'(hold), 32'(port7_pin_out));
		sleep_mode <= 1'b0;
		repeat (3) @(posedge aclk);
		chk("wake out", 32'(~d7 & c7), 32'(port7_pin_out & c7));
		s_axi_wstrb <= 4'h0;
		wr(`PORT7_DIRECTION_ADDR, 32'h000000ff);
		s_axi_wstrb <= 4'hf;
		chk("masked bresp", 32'(`RESP_OKAY), 32'(s_axi_bresp));
		rdt(`PORT7_DATA_ADDR);
		chk("masked write", 32'(rd_exp(~d7, c7, s7)), rd);
		wr('0, 32'h000000ff);
		chk("unmapped bresp", 32'(`RESP_SLVERR), 32'(s_axi_bresp));
		rdt('0);
		chk("unmapped rresp", 32'(`RESP_SLVERR), 32'(rr));
		chk("unmapped rdata", 32'h0, rd);
		stop_test();
	end
endmodule // tb_top
bind gpio_port78 gpio_port78_sva #(.WIDTH(WIDTH)) sva_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
	.s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .standby_mode, .sleep_mode, .lcd_segment_out_p7,
	.lcd_segment_out_p8, .lcd_clock_one_out, .port7_pin_out, .port7_pin_oe, .port8_pin_out, .port8_pin_oe);
`default_nettype wire
